/* dv/odt_decoder_asserts.sv */
// checker: stream, hold and decode relations of the opcode decoder
module odt_decoder_asserts
   import odt_pkg::*;
(
   // stream side
   input wire logic       ref_clk_i,
   input wire logic       arst_n_i,
   input wire logic [7:0] byte_i,
   input wire logic       byte_valid_i,
   input wire logic       byte_ready_o,
   // result side
   input wire logic       dec_valid_o,
   input wire logic       dec_ready_i,
   input odt_class_t      dec_class_o,
   input wire logic [7:0] dec_opcode_o,
   input wire logic       dec_has_modrm_o,
   input wire logic [1:0] dec_mod_o,
   input wire logic [2:0] dec_reg_o,
   input wire logic [2:0] dec_rm_o,
   input wire logic       dec_word_o,
   input wire logic       dec_reg_is_dest_o,
   input wire logic       dec_ea_only_o,
   input odt_seg_t        dec_seg_dest_o,
   input wire logic       dec_seg_field_err_o
);
   logic       take;
   logic       pair;
   logic       mrm_reg;
   logic [7:0] op_reg;
   assign take = byte_valid_i && byte_ready_o;
   assign pair = (byte_i inside {8'h8c, 8'h8d, 8'h8e, 8'hc4, 8'hc5})
                 || byte_i[7:2] == 6'h00;
   // own copy of the opcode/modrm phase, kept apart from the design's
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
      if (!arst_n_i)
         mrm_reg <= 1'b0;
      else if (take)
         mrm_reg <= !mrm_reg && pair;
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
      if (!arst_n_i)
         op_reg <= 8'h00;
      else if (take && !mrm_reg)
         op_reg <= byte_i;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   a_ready_back_press:
      assert property (byte_ready_o == (!dec_valid_o || dec_ready_i))
      else $error("ready not tied to result handshake");
   a_result_held:
      assert property (dec_valid_o && !dec_ready_i |=> dec_valid_o
         && $stable(dec_opcode_o) && $stable(dec_class_o))
      else $error("result changed while stalled");
   a_single_done:
      assert property (take && !mrm_reg && !pair |=> dec_valid_o
         && !dec_has_modrm_o && dec_opcode_o == $past(byte_i))
      else $error("one-byte opcode not finished");
   a_wait_modrm:
      assert property (take && !mrm_reg && pair |=> !dec_valid_o)
      else $error("result before modrm byte");
   a_modrm_fields:
      assert property (take && mrm_reg |=> dec_valid_o && dec_has_modrm_o
         && {dec_mod_o, dec_reg_o, dec_rm_o} == $past(byte_i))
      else $error("modrm fields wrong");
   a_ea_load:
      assert property (take && mrm_reg && op_reg == ODT_OP_EA_LOAD |=>
         dec_class_o == ODT_CL_EA_LOAD && dec_ea_only_o && dec_reg_is_dest_o)
      else $error("address load decode wrong");
   a_ptr_segment:
      assert property (take && mrm_reg && op_reg[7:1] == 7'h62 |=>
         dec_seg_dest_o == (op_reg[0] ? ODT_SEG_DATA : ODT_SEG_EXTR))
      else $error("pointer load segment wrong");
   a_add_fields:
      assert property (take && mrm_reg && op_reg[7:2] == 6'h00 |=>
         dec_class_o == ODT_CL_ADD_REG && dec_word_o == op_reg[0]
         && dec_reg_is_dest_o == op_reg[1])
      else $error("add direction or width wrong");
   a_seg_load:
      assert property (take && mrm_reg && op_reg == ODT_OP_SEG_LOAD |=>
         dec_class_o == ODT_CL_TRANSFER_LDSR
         && dec_seg_field_err_o == dec_reg_o[2])
      else $error("segment load decode wrong");
   c_stall: cover property (dec_valid_o && !dec_ready_i && byte_valid_i);
   c_pair: cover property (take && mrm_reg);
   c_back: cover property (take && dec_valid_o);
endmodule // odt_decoder_asserts

/* dv/odt_decoder_test.sv */
// testbench: scenario tasks driving the opcode decoder through its model
module odt_decoder_test
   import odt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i, arst_n_i, byte_valid_i, byte_ready_o, dec_valid_o;
   logic dec_ready_i, dec_known_o, dec_has_modrm_o, dec_word_o;
   logic dec_reg_is_dest_o, dec_mem_operand_o, dec_ea_only_o;
   logic dec_seg_src_o, dec_seg_field_err_o;
   logic [7:0] byte_i, dec_opcode_o;
   logic [1:0] dec_mod_o;
   logic [2:0] dec_reg_o, dec_rm_o;
   odt_class_t dec_class_o;
   odt_seg_t   dec_seg_dest_o;
   int         n_mismatch = 0;
   int         compares = 0;
   initial
   begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   odt_decoder dut (.ref_clk_i, .arst_n_i, .byte_i, .byte_valid_i,
      .byte_ready_o, .dec_valid_o, .dec_ready_i, .dec_class_o, .dec_known_o,
      .dec_opcode_o, .dec_has_modrm_o, .dec_mod_o, .dec_reg_o, .dec_rm_o,
      .dec_word_o, .dec_reg_is_dest_o, .dec_mem_operand_o, .dec_ea_only_o,
      .dec_seg_dest_o, .dec_seg_src_o, .dec_seg_field_err_o);
   odt_feed_model feed (.clk_i(ref_clk_i), .ready_i(byte_ready_o),
      .byte_o(byte_i), .valid_o(byte_valid_i), .take_o(dec_ready_i));
   // ********************************************************
   // checking helpers
   // ********************************************************
   function automatic logic [31:0] seen();
      return {dec_valid_o, dec_has_modrm_o, dec_class_o, dec_opcode_o,
         dec_mod_o, dec_reg_o, dec_rm_o, dec_word_o, dec_reg_is_dest_o,
         dec_known_o, dec_mem_operand_o, dec_ea_only_o, dec_seg_src_o,
         dec_seg_field_err_o, 1'b0, dec_seg_dest_o};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic t_one(input logic [7:0] op, input odt_class_t cls);
      feed.send(op);
      chk(seen(),
         {2'b10, cls, op, 10'h000, cls != ODT_CL_NONE, 7'h00});
   endtask
   task automatic t_two(input logic [7:0] op, m, input odt_class_t cls,
                        input odt_seg_t seg);
      logic        sg;
      logic [31:0] mk;
      sg = op inside {8'h8c, 8'h8e};
      // direction of segment moves and store target left to the designer
      mk = ~({23'h0, sg, 6'h00, op == 8'h8c, op == 8'h8c});
      feed.send(op);
      feed.send(m);
      chk(seen() & mk,
         {2'b11, cls, op, m, op[7:2] == 6'h00 ? {op[0], op[1]} : 2'b11,
         1'b1, m[7:6] != 2'b11, cls == ODT_CL_EA_LOAD,
         cls == ODT_CL_TRANSFER_STSR, sg && m[5], 1'b0, seg} & mk);
   endtask
   task automatic t_stall;
      // let the last result drain before the datapath stops taking
      @(posedge ref_clk_i);
      #1;
      feed.stall = 1'b1;
      feed.send(ODT_OP_AH_TO_FLG);
      fork
         feed.send(ODT_OP_FLG_TO_AH);
         begin
            repeat (3) @(posedge ref_clk_i);
            #1;
            chk({31'h0, byte_ready_o}, 32'h0);
            chk(seen(),
               {2'b10, ODT_CL_AH_TO_FLAGS, 8'h9e, 11'h001, 7'h00});
            feed.stall = 1'b0;
         end
      join
      chk(seen(),
         {2'b10, ODT_CL_FLAGS_TO_AH, 8'h9f, 11'h001, 7'h00});
   endtask
   task automatic t_reset;
      feed.send(ODT_OP_EA_LOAD);
      arst_n_i = 1'b0;
      #8;
      chk({30'h0, byte_ready_o, dec_valid_o}, 32'h2);
      chk(seen(), 32'h0);
      arst_n_i = 1'b1;
      t_one(ODT_OP_FLG_TO_AH, ODT_CL_FLAGS_TO_AH);
   endtask
   initial
   begin
      arst_n_i = 1'b0;
      repeat (10) @(posedge ref_clk_i);
      #1;
      arst_n_i = 1'b1;
      t_one(ODT_OP_TABLE_LOOKUP_TRANSLATE_TBL, ODT_CL_TABLE_TABLE_LOOKUP_TRANSLATE);
      t_one(ODT_OP_FLG_TO_AH, ODT_CL_FLAGS_TO_AH);
      t_one(ODT_OP_AH_TO_FLG, ODT_CL_AH_TO_FLAGS);
      t_one(8'h9c, ODT_CL_NONE);
      t_two(8'h8e, 8'h18, ODT_CL_TRANSFER_LDSR, ODT_SEG_SEL);
      t_two(8'h8e, 8'hea, ODT_CL_TRANSFER_LDSR, ODT_SEG_SEL);
      t_two(8'h8c, 8'hc3, ODT_CL_TRANSFER_STSR, ODT_SEG_NONE);
      t_two(8'h8d, 8'h46, ODT_CL_EA_LOAD, ODT_SEG_NONE);
      t_two(8'hc5, 8'h1e, ODT_CL_PTR_LOAD_DS, ODT_SEG_DATA);
      t_two(8'hc4, 8'h99, ODT_CL_PTR_LOAD_ES, ODT_SEG_EXTR);
      for (int i = 0; i < 4; i++)
         t_two({6'h00, i[1:0]}, {6'h32, i[1:0]},
            ODT_CL_ADD_REG, ODT_SEG_NONE);
      t_stall;
      t_reset;
      end_of_test;
   end
   initial
   begin
      #20000;
      n_mismatch++;
      end_of_test;
   end
endmodule // odt_decoder_test
bind odt_decoder odt_decoder_asserts chk_u (.ref_clk_i, .arst_n_i, .byte_i,
   .byte_valid_i, .byte_ready_o, .dec_valid_o, .dec_ready_i, .dec_class_o,
   .dec_opcode_o, .dec_has_modrm_o, .dec_mod_o, .dec_reg_o, .dec_rm_o,
   .dec_word_o, .dec_reg_is_dest_o, .dec_ea_only_o, .dec_seg_dest_o,
   .dec_seg_field_err_o);

/* dv/odt_feed_model.sv */
// partner model: prefetch queue offering bytes, datapath taking results
module odt_feed_model
(
   // handshake
   input wire logic   clk_i,
   input wire logic   ready_i,
   output logic [7:0] byte_o,
   output logic       valid_o,
   output logic       take_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic stall = 1'b0;
   logic r;
   assign take_o = !stall;
   initial
   begin
      byte_o = 8'h00;
      valid_o = 1'b0;
   end
   // called just after a rising edge; holds the byte until taken
   task automatic send(input logic [7:0] b);
      // one idle edge first, so valid never drops and rises in one step
      @(posedge clk_i);
      #1;
      byte_o = b;
      valid_o = 1'b1;
      do
      begin
         @(negedge clk_i);
         r = ready_i;
         @(posedge clk_i);
      end while (!r);
      #1;
      valid_o = 1'b0;
      byte_o = ~b; // released bus must not show the stale byte
   endtask
endmodule // odt_feed_model

/* hdl/odt_decoder.sv */
// data-transfer and register-add opcode decoder, byte-serial from prefetch
module odt_decoder
   import odt_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       arst_n_i,
   // byte stream from prefetch queue
   input  wire logic [7:0] byte_i,
   input  wire logic       byte_valid_i,
   output logic            byte_ready_o,
   // decoded instruction to execution datapath
   output logic            dec_valid_o,
   input  wire logic       dec_ready_i,
   output odt_class_t      dec_class_o,
   output logic            dec_known_o,
   output logic [7:0]      dec_opcode_o,
   output logic            dec_has_modrm_o,
   output logic [1:0]      dec_mod_o,
   output logic [2:0]      dec_reg_o,
   output logic [2:0]      dec_rm_o,
   output logic            dec_word_o,
   output logic            dec_reg_is_dest_o,
   output logic            dec_mem_operand_o,
   output logic            dec_ea_only_o,
   output odt_seg_t        dec_seg_dest_o,
   output logic            dec_seg_src_o,
   output logic            dec_seg_field_err_o
);

   // ******************************************************************
   // state
   // ******************************************************************
   odt_state_t state_reg;
   odt_class_t class_reg;
   odt_class_t fb_class;
   logic       fb_modrm;
   logic [7:0] opcode_reg;
   logic [7:0] modrm_reg;
   logic       has_modrm_reg;
   logic       out_valid_reg;
   logic       take;
   logic       finish_one;
   logic       finish_two;

   odt_first_byte u_first_byte
   (
      .opcode_i      (byte_i),
      .op_class_o    (fb_class),
      .needs_modrm_o (fb_modrm)
   );

   // ******************************************************************
   // helpers
   // ******************************************************************
   // the next accepted byte opens a new instruction
   function automatic logic at_opcode(input odt_state_t st);
      return st == ODT_ST_OPCODE;
   endfunction

   // a held result stalls the queue so no byte slips past the datapath
   assign byte_ready_o = !out_valid_reg || dec_ready_i;
   assign take         = byte_valid_i && byte_ready_o;
   assign finish_one   = take && at_opcode(state_reg) && !fb_modrm;
   assign finish_two   = take && (state_reg == ODT_ST_MODRM);

   // ******************************************************************
   // sequencing
   // ******************************************************************
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_reg <= ODT_ST_OPCODE;
      end
      else if (take)
      begin
         case (state_reg)
            ODT_ST_OPCODE:
            begin
               // unknown opcodes pass as one byte so the stream never locks
               state_reg <= fb_modrm ? ODT_ST_MODRM : ODT_ST_OPCODE;
            end
            ODT_ST_MODRM:
            begin
               state_reg <= ODT_ST_OPCODE;
            end
            default:
            begin
               state_reg <= ODT_ST_OPCODE;
            end
         endcase
      end
   end

   // ******************************************************************
   // captured bytes
   // ******************************************************************
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         opcode_reg    <= ODT_BYTE_RST;
         class_reg     <= ODT_CL_NONE;
         has_modrm_reg <= 1'b0;
      end
      else if (take && at_opcode(state_reg))
      begin
         opcode_reg    <= byte_i;
         class_reg     <= fb_class;
         has_modrm_reg <= fb_modrm;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         modrm_reg <= ODT_BYTE_RST;
      end
      else if (finish_one)
      begin
         // single-byte forms carry no addressing byte
         modrm_reg <= ODT_BYTE_RST;
      end
      else if (finish_two)
      begin
         modrm_reg <= byte_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         out_valid_reg <= 1'b0;
      end
      else if (finish_one || finish_two)
      begin
         out_valid_reg <= 1'b1;
      end
      else if (dec_ready_i)
      begin
         out_valid_reg <= 1'b0;
      end
   end

   // ******************************************************************
   // result fields
   // ******************************************************************
   assign dec_valid_o     = out_valid_reg;
   assign dec_class_o     = class_reg;
   assign dec_known_o     = (class_reg != ODT_CL_NONE);
   assign dec_opcode_o    = opcode_reg;
   assign dec_has_modrm_o = has_modrm_reg;
   assign dec_mod_o       = modrm_reg[ODT_MOD_LSB +: 2];
   assign dec_reg_o       = modrm_reg[ODT_REG_LSB +: 3];
   assign dec_rm_o        = modrm_reg[ODT_RM_LSB +: 3];
   // mod 11 names a register; any other mod reaches memory
   assign dec_mem_operand_o = has_modrm_reg && (dec_mod_o != 2'b11);

   always_comb
   begin
      dec_word_o          = 1'b0;
      dec_reg_is_dest_o   = 1'b0;
      dec_ea_only_o       = 1'b0;
      dec_seg_dest_o      = ODT_SEG_NONE;
      dec_seg_src_o       = 1'b0;
      dec_seg_field_err_o = 1'b0;
      case (class_reg)
         ODT_CL_ADD_REG:
         begin
            dec_word_o        = opcode_reg[ODT_W_BIT];
            dec_reg_is_dest_o = opcode_reg[ODT_D_BIT];
         end
         ODT_CL_TRANSFER_LDSR:
         begin
            // reg field names a segment register, not a general one
            dec_word_o          = 1'b1;
            dec_seg_dest_o      = ODT_SEG_SEL;
            // flagged, not refused: the datapath decides how to trap
            dec_seg_field_err_o = modrm_reg[ODT_SEGZERO_BIT];
         end
         ODT_CL_TRANSFER_STSR:
         begin
            dec_word_o          = 1'b1;
            dec_seg_src_o       = 1'b1;
            dec_seg_field_err_o = modrm_reg[ODT_SEGZERO_BIT];
         end
         ODT_CL_EA_LOAD:
         begin
            dec_word_o        = 1'b1;
            dec_reg_is_dest_o = 1'b1;
            dec_ea_only_o     = 1'b1;
         end
         ODT_CL_PTR_LOAD_DS:
         begin
            dec_word_o        = 1'b1;
            dec_reg_is_dest_o = 1'b1;
            dec_seg_dest_o    = ODT_SEG_DATA;
         end
         ODT_CL_PTR_LOAD_ES:
         begin
            dec_word_o        = 1'b1;
            dec_reg_is_dest_o = 1'b1;
            dec_seg_dest_o    = ODT_SEG_EXTR;
         end
         default:
         begin
            dec_word_o = 1'b0;
         end
      endcase
   end

endmodule // odt_decoder

/* hdl/odt_first_byte.sv */
// first-byte classifier: maps an opcode byte to a class and modrm need
module odt_first_byte
   import odt_pkg::*;
(
   // opcode in
   input  wire logic [7:0] opcode_i,
   // classification out
   output odt_class_t      op_class_o,
   output logic            needs_modrm_o
);

   always_comb
   begin
      op_class_o    = ODT_CL_NONE;
      needs_modrm_o = 1'b0;
      if (opcode_i == ODT_OP_SEG_LOAD)
      begin
         op_class_o    = ODT_CL_TRANSFER_LDSR;
         needs_modrm_o = 1'b1;
      end
      else if (opcode_i == ODT_OP_SEG_STORE)
      begin
         op_class_o    = ODT_CL_TRANSFER_STSR;
         needs_modrm_o = 1'b1;
      end
      else if (opcode_i == ODT_OP_EA_LOAD)
      begin
         op_class_o    = ODT_CL_EA_LOAD;
         needs_modrm_o = 1'b1;
      end
      else if (opcode_i == ODT_OP_PTR_DS)
      begin
         op_class_o    = ODT_CL_PTR_LOAD_DS;
         needs_modrm_o = 1'b1;
      end
      else if (opcode_i == ODT_OP_PTR_ES)
      begin
         op_class_o    = ODT_CL_PTR_LOAD_ES;
         needs_modrm_o = 1'b1;
      end
      else if (opcode_i == ODT_OP_TABLE_LOOKUP_TRANSLATE_TBL)
      begin
         op_class_o = ODT_CL_TABLE_TABLE_LOOKUP_TRANSLATE;
      end
      else if (opcode_i == ODT_OP_FLG_TO_AH)
      begin
         op_class_o = ODT_CL_FLAGS_TO_AH;
      end
      else if (opcode_i == ODT_OP_AH_TO_FLG)
      begin
         op_class_o = ODT_CL_AH_TO_FLAGS;
      end
      else if (opcode_i[7:ODT_PFX_LSB] == ODT_ADD_PREFIX)
      begin
         op_class_o    = ODT_CL_ADD_REG;
         needs_modrm_o = 1'b1;
      end
   end

endmodule // odt_first_byte

/* hdl/odt_pkg.sv */
// package: opcode patterns, field positions and enumerations for the decoder
//
// Contract
// - byte 8e decodes as load segment register from register or memory
// - byte 8c decodes as store segment register to register or memory
// - byte 8d with modrm writes effective address into general register
// - byte c5 with modrm loads offset to register, segment to data seg
// - byte c4 with modrm loads offset to register, segment to extra seg
// - byte d7 alone translates low accumulator byte through a table
// - byte 9f alone copies low flags into high accumulator byte
// - byte 9e alone writes high accumulator byte into low flags
// - bytes 000000dw with modrm decode as register/memory addition
package odt_pkg;

   // ******************************************************************
   // opcode patterns
   // ******************************************************************
   localparam logic [7:0] ODT_OP_SEG_LOAD   = 8'h8e;
   localparam logic [7:0] ODT_OP_SEG_STORE  = 8'h8c;
   localparam logic [7:0] ODT_OP_EA_LOAD    = 8'h8d;
   localparam logic [7:0] ODT_OP_PTR_DS     = 8'hc5;
   localparam logic [7:0] ODT_OP_PTR_ES     = 8'hc4;
   localparam logic [7:0] ODT_OP_TABLE_LOOKUP_TRANSLATE_TBL   = 8'hd7;
   localparam logic [7:0] ODT_OP_FLG_TO_AH  = 8'h9f;
   localparam logic [7:0] ODT_OP_AH_TO_FLG  = 8'h9e;
   localparam logic [5:0] ODT_ADD_PREFIX    = 6'h00;

   // ******************************************************************
   // field positions
   // ******************************************************************
   localparam int ODT_W_BIT       = 0;
   localparam int ODT_D_BIT       = 1;
   localparam int ODT_PFX_LSB     = 2;
   localparam int ODT_MOD_LSB     = 6;
   localparam int ODT_REG_LSB     = 3;
   localparam int ODT_RM_LSB      = 0;
   localparam int ODT_SEGZERO_BIT = 5;

   // ******************************************************************
   // reset values
   // ******************************************************************
   localparam logic [7:0] ODT_BYTE_RST = 8'h00;

   // ******************************************************************
   // decoded operation classes
   // ******************************************************************
   typedef enum logic [3:0] {
      ODT_CL_NONE          = 4'b0000,
      ODT_CL_TRANSFER_LDSR = 4'b0001,
      ODT_CL_TRANSFER_STSR = 4'b0010,
      ODT_CL_EA_LOAD       = 4'b0011,
      ODT_CL_PTR_LOAD_DS   = 4'b0100,
      ODT_CL_PTR_LOAD_ES   = 4'b0101,
      ODT_CL_TABLE_TABLE_LOOKUP_TRANSLATE    = 4'b0110,
      ODT_CL_FLAGS_TO_AH   = 4'b0111,
      ODT_CL_AH_TO_FLAGS   = 4'b1000,
      ODT_CL_ADD_REG       = 4'b1001
   } odt_class_t;

   typedef enum logic [1:0] {
      ODT_ST_OPCODE = 2'b00,
      ODT_ST_MODRM  = 2'b01
   } odt_state_t;

   // segment destination/source encodings for the datapath
   typedef enum logic [1:0] {
      ODT_SEG_NONE = 2'b00,
      ODT_SEG_SEL  = 2'b01,
      ODT_SEG_DATA = 2'b10,
      ODT_SEG_EXTR = 2'b11
   } odt_seg_t;

endpackage
